/* hw/cfgc_top.sv */
/*
  Configuration control pins: init handshake, straps, oscillator,
  activity and done outputs, host port, ready pin, scan gating,
  and an APB register slave.
  Assumes all pins synchronous to CORE_CLK and external pin resolution.
*/
// Behaviour
// - capture speed-select level on the init pin rising edge
// - oscillator at 10 MHz for low speed select, 1.25 MHz for high
// - boundary scan disabled after configuration unless selected
// - pull-ups on test pins while configuring
// - byte-ready in peripheral mode when another byte fits
// - ready status on data bit for selected async read
// - master parallel mode drives ready pin as memory read strobe
// - muxed processor mode makes ready pin the address latch enable input
// - active-high output high until configuration completes
// - active-low output low until configuration completes
// - init pin driven low, open-drain, while memory clears
// - init held low outside keeps device waiting
// - internal pull-up on init pin while configuring
// - control and unused test pins released as user I/O when done
// - capture three mode-select pins on the init pin rising edge
// - done output released high when configuration is complete
// - selected host read strobe low in async peripheral mode makes data bit a ready/busy status
`timescale 1ns/1ps
`default_nettype none
module cfgc_top
  import cfgc_pkg::*;
#(
  parameter int CLEAR_CYCLES_P = CLEAR_CYCLES
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // restart pins
  input wire logic PRGM_N,
  input wire logic CFG_RESET_N,
  // straps
  input wire logic OSC_SPEED_SELECT,
  input wire logic [2:0] CFG_MODE_SELECT,
  // init handshake pin
  input wire logic INIT_IN,
  output logic INIT_OUT,
  output logic INIT_OE_N,
  output logic INIT_PULLUP_EN,
  // done pin and activity outputs
  output logic DONE_OUT,
  output logic DONE_OE_N,
  output logic CFG_ACTIVE_HIGH,
  output logic CFG_ACTIVE_LOW,
  // peripheral host pins
  input wire logic SELECT_LOW_ACTIVE_N,
  input wire logic SELECT_HIGH_ACTIVE,
  input wire logic HOST_WR_N,
  input wire logic HOST_RD_N,
  input wire logic [7:0] HOST_DATA_IN,
  output logic STATUS_DATA_BIT_OUT,
  output logic STATUS_DATA_BIT_OE_N,
  // shared ready pin
  input wire logic READY_PIN_IN,
  output logic READY_PIN_OUT,
  output logic READY_PIN_OE_N,
  // oscillator and test/user pin control
  output logic CFG_OSC_TICK,
  output logic TEST_PULLUP_EN,
  output logic BSCAN_ENABLE,
  output logic USER_IO_RELEASE,
  output logic TEST_IO_RELEASE
);
  // ==========================================================
  // reset release
  logic rst_s1_r;
  logic rst_n;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // ==========================================================
  // helpers
  function automatic logic mode_is(input logic [2:0] m, input logic [2:0] code);
    mode_is = (m == code);
  endfunction : mode_is

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == OFS_CTRL) | (a == OFS_STATUS) | (a == OFS_DATA) | (a == OFS_ALE_ADDR);
  endfunction : reg_hit

  // ==========================================================
  // declarations
  cfgc_state_t state_r;
  cfgc_state_t state_nxt;
  logic [15:0] clr_cnt_r;
  logic init_prev_r;
  logic init_rise;
  logic speed_r;
  logic [2:0] mode_r;
  logic bscan_sel_r;
  logic complete_pulse_r;
  logic restart_pulse_r;
  logic restart_req;
  logic in_cfg;
  logic periph_mode;
  logic selected;
  logic [7:0] ale_addr_r;
  logic host_ready;
  logic osc_tick;
  logic access;
  logic xfer_done;
  logic [31:0] rd_mux;
  logic [1:0] state_code;
  cfgc_byte_if byte_link ();

  // ==========================================================
  // sequencing
  assign restart_req = ~PRGM_N | ~CFG_RESET_N | restart_pulse_r;
  // no init edge while held low outside, so we wait
  assign init_rise = INIT_IN & ~init_prev_r;
  assign in_cfg = (state_r == ST_CONFIG);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_POWERUP: begin
        if (clr_cnt_r >= 16'(CLEAR_CYCLES_P - 1)) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (init_rise) begin
          state_nxt = ST_CONFIG;
        end
      end
      ST_CONFIG: begin
        if (complete_pulse_r) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_DONE;
      end
      default: begin
        state_nxt = ST_POWERUP;
      end
    endcase
    if (restart_req) begin
      state_nxt = ST_POWERUP;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_POWERUP;
      clr_cnt_r <= 16'h0000;
      init_prev_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      init_prev_r <= INIT_IN;
      if (state_nxt == ST_POWERUP && state_r == ST_POWERUP) begin
        clr_cnt_r <= clr_cnt_r + 16'h0001;
      end else begin
        clr_cnt_r <= 16'h0000;
      end
    end
  end

  // straps caught on the init edge only
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      speed_r <= 1'b0;
      mode_r <= 3'h0;
    end else if (state_r == ST_WAIT && init_rise && !restart_req) begin
      speed_r <= OSC_SPEED_SELECT;
      mode_r <= CFG_MODE_SELECT;
    end
  end

  // ==========================================================
  // pin control from next state, so activity outputs agree
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      INIT_OUT <= 1'b0;
      INIT_OE_N <= 1'b0;
      INIT_PULLUP_EN <= 1'b1;
      TEST_PULLUP_EN <= 1'b1;
      DONE_OUT <= 1'b0;
      DONE_OE_N <= 1'b0;
      CFG_ACTIVE_HIGH <= 1'b1;
      CFG_ACTIVE_LOW <= 1'b0;
      BSCAN_ENABLE <= 1'b1;
      USER_IO_RELEASE <= 1'b0;
      TEST_IO_RELEASE <= 1'b0;
    end else begin
      INIT_OUT <= 1'b0;
      INIT_OE_N <= (state_nxt != ST_POWERUP);
      INIT_PULLUP_EN <= (state_nxt != ST_DONE);
      TEST_PULLUP_EN <= (state_nxt != ST_DONE);
      DONE_OUT <= 1'b0;
      DONE_OE_N <= (state_nxt == ST_DONE);
      CFG_ACTIVE_HIGH <= (state_nxt != ST_DONE);
      CFG_ACTIVE_LOW <= (state_nxt == ST_DONE);
      BSCAN_ENABLE <= ~((state_nxt == ST_DONE) & ~bscan_sel_r);
      USER_IO_RELEASE <= (state_nxt == ST_DONE);
      TEST_IO_RELEASE <= (state_nxt == ST_DONE) & ~bscan_sel_r;
    end
  end

  // ==========================================================
  // oscillator
  cfgc_osc_div u_osc (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .run(in_cfg),
    .slow(speed_r),
    .tick_r(osc_tick)
  );

  assign CFG_OSC_TICK = osc_tick;

  // ==========================================================
  // peripheral host port
  assign periph_mode = mode_is(mode_r, MODE_ASYNC_PERIPH) | mode_is(mode_r, MODE_SYNC_PERIPH);
  assign selected = ~SELECT_LOW_ACTIVE_N & SELECT_HIGH_ACTIVE;

  cfgc_host_port u_host (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .enable(in_cfg & periph_mode),
    .async_mode(mode_is(mode_r, MODE_ASYNC_PERIPH)),
    .sel_n(SELECT_LOW_ACTIVE_N),
    .sel(SELECT_HIGH_ACTIVE),
    .wr_n(HOST_WR_N),
    .rd_n(HOST_RD_N),
    .din(HOST_DATA_IN),
    .ready_r(host_ready),
    .d7_out_r(STATUS_DATA_BIT_OUT),
    .d7_oe_n_r(STATUS_DATA_BIT_OE_N),
    .byte_o(byte_link.port)
  );

  // ==========================================================
  // shared ready pin
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      READY_PIN_OUT <= 1'b0;
      READY_PIN_OE_N <= 1'b1;
    end else if (in_cfg && mode_is(mode_r, MODE_MASTER_PAR)) begin
      READY_PIN_OUT <= ~osc_tick;
      READY_PIN_OE_N <= 1'b0;
    end else if (in_cfg && periph_mode) begin
      READY_PIN_OUT <= host_ready;
      READY_PIN_OE_N <= 1'b0;
    end else begin
      // input: address latch enable, or user I/O after done
      READY_PIN_OUT <= 1'b0;
      READY_PIN_OE_N <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      ale_addr_r <= 8'h00;
    end else if (in_cfg && mode_is(mode_r, MODE_MPI_MUX) && selected && READY_PIN_IN) begin
      ale_addr_r <= HOST_DATA_IN;
    end
  end

  // ==========================================================
  // apb slave: one wait state, errors on unmapped or read-only writes
  assign access = PSEL & PENABLE;
  assign xfer_done = access & PREADY;
  assign state_code = state_r;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (PADDR)
      OFS_CTRL: begin
        rd_mux[CTRL_BSCAN_SEL_BIT] = bscan_sel_r;
      end
      OFS_STATUS: begin
        rd_mux[STAT_STATE_LSB +: 2] = state_code;
        rd_mux[STAT_SPEED_BIT] = speed_r;
        rd_mux[STAT_MODE_LSB +: 3] = mode_r;
        rd_mux[STAT_READY_BIT] = host_ready;
        rd_mux[STAT_DONE_BIT] = (state_r == ST_DONE);
        rd_mux[STAT_BSCAN_BIT] = BSCAN_ENABLE;
      end
      OFS_DATA: begin
        rd_mux[7:0] = byte_link.data;
        rd_mux[DATA_VALID_BIT] = byte_link.valid;
      end
      OFS_ALE_ADDR: begin
        rd_mux[7:0] = ale_addr_r;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // only a read that saw valid consumes, so a late byte stays
  assign byte_link.take = xfer_done & ~PWRITE & (PADDR == OFS_DATA) & PRDATA[DATA_VALID_BIT];

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= access & ~PREADY;
      if (access && !PREADY) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
        PSLVERR <= ~reg_hit(PADDR) | (PWRITE & (PADDR != OFS_CTRL));
      end else if (!access) begin
        PRDATA <= 32'h0000_0000;
        PSLVERR <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      bscan_sel_r <= CTRL_RST[CTRL_BSCAN_SEL_BIT];
      complete_pulse_r <= 1'b0;
      restart_pulse_r <= 1'b0;
    end else begin
      complete_pulse_r <= 1'b0;
      restart_pulse_r <= 1'b0;
      if (xfer_done && PWRITE && PADDR == OFS_CTRL && PSTRB[0]) begin
        bscan_sel_r <= PWDATA[CTRL_BSCAN_SEL_BIT];
        complete_pulse_r <= PWDATA[CTRL_COMPLETE_BIT];
        restart_pulse_r <= PWDATA[CTRL_RESTART_BIT];
      end
    end
  end
endmodule : cfgc_top
`default_nettype wire

/* hw/cfgc_pkg.sv */
/*
  Constants and types of the configuration control-pin block:
  register map, fields, mode codes, timing.
  Assumes a single core clock at CORE_CLK_HZ.
*/
package cfgc_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_ALE_ADDR = 8'h0c;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CTRL_BSCAN_SEL_BIT = 0;
  localparam int CTRL_COMPLETE_BIT = 1;
  localparam int CTRL_RESTART_BIT = 2;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_SPEED_BIT = 2;
  localparam int STAT_MODE_LSB = 4;
  localparam int STAT_READY_BIT = 7;
  localparam int STAT_DONE_BIT = 8;
  localparam int STAT_BSCAN_BIT = 9;
  localparam int DATA_VALID_BIT = 8;
  // ==========================================================
  // configuration mode codes (captured from cfg_mode_select)
  localparam logic [2:0] MODE_MASTER_PAR = 3'h4;
  localparam logic [2:0] MODE_ASYNC_PERIPH = 3'h5;
  localparam logic [2:0] MODE_SYNC_PERIPH = 3'h6;
  localparam logic [2:0] MODE_MPI_MUX = 3'h7;
  // ==========================================================
  // timing
  localparam int CORE_CLK_HZ = 10_000_000;
  localparam int OSC_FAST_HZ = 10_000_000;
  localparam int OSC_SLOW_HZ = 1_250_000;
  localparam int OSC_DIV_FAST = CORE_CLK_HZ / OSC_FAST_HZ;
  localparam int OSC_DIV_SLOW = CORE_CLK_HZ / OSC_SLOW_HZ;
  localparam int CLEAR_TIME_NS = 10_000;
  localparam int CLEAR_CYCLES = (CLEAR_TIME_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ST_POWERUP,
    ST_WAIT,
    ST_CONFIG,
    ST_DONE
  } cfgc_state_t;
endpackage : cfgc_pkg

/* hw/cfgc_byte_if.sv */
/*
  One-byte hand-over between the host pin port and the core.
  Assumes both ends on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface cfgc_byte_if;
  logic [7:0] data;
  logic valid;
  logic take;
  modport port (output data, output valid, input take);
  modport core (input data, input valid, output take);
endinterface : cfgc_byte_if
`default_nettype wire

/* hw/cfgc_osc_div.sv */
/*
  Configuration oscillator: a one-cycle tick at the fast or slow rate.
  Assumes the core clock runs at CORE_CLK_HZ.
*/
`timescale 1ns/1ps
`default_nettype none
module cfgc_osc_div
  import cfgc_pkg::*;
#(
  parameter int DIV_FAST = OSC_DIV_FAST,
  parameter int DIV_SLOW = OSC_DIV_SLOW
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic slow,
  // output
  output logic tick_r
);
  // ==========================================================
  // divider
  logic [7:0] cnt_r;
  logic [7:0] top;
  assign top = slow ? 8'(DIV_SLOW - 1) : 8'(DIV_FAST - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end else if (!run) begin
      cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end else if (cnt_r >= top) begin
      cnt_r <= 8'h00;
      tick_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      tick_r <= 1'b0;
    end
  end
endmodule : cfgc_osc_div
`default_nettype wire

/* hw/cfgc_host_port.sv */
/*
  Host port: one-byte buffer, byte-ready, data-bit status.
  Assumes host pins synchronous to the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module cfgc_host_port (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // mode
  input wire logic enable,
  input wire logic async_mode,
  // host pins
  input wire logic sel_n,
  input wire logic sel,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [7:0] din,
  // outputs
  output logic ready_r,
  output logic d7_out_r,
  output logic d7_oe_n_r,
  // core side
  cfgc_byte_if.port byte_o
);
  // ==========================================================
  // strobe decode
  logic wr_prev_r;
  logic selected;
  logic wr_fall;
  logic rd_active;
  logic valid_r;
  logic valid_nxt;
  logic [7:0] data_r;
  logic load;

  assign selected = enable & ~sel_n & sel;
  assign wr_fall = selected & ~wr_n & wr_prev_r;
  // write strobe overrides a simultaneous read
  assign rd_active = selected & async_mode & ~rd_n & wr_n;
  // take and write together: the write lands
  assign load = wr_fall & (~valid_r | byte_o.take);

  always_comb begin
    valid_nxt = valid_r;
    if (byte_o.take) begin
      valid_nxt = 1'b0;
    end
    if (load) begin
      valid_nxt = 1'b1;
    end
    if (!enable) begin
      valid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_prev_r <= 1'b1;
      valid_r <= 1'b0;
      data_r <= 8'h00;
    end else begin
      wr_prev_r <= wr_n;
      valid_r <= valid_nxt;
      if (load) begin
        data_r <= din;
      end
    end
  end

  // ==========================================================
  // ready indications
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_r <= 1'b0;
      d7_out_r <= 1'b0;
      d7_oe_n_r <= 1'b1;
    end else begin
      ready_r <= enable & ~valid_nxt;
      d7_out_r <= enable & ~valid_nxt;
      d7_oe_n_r <= ~rd_active;
    end
  end

  assign byte_o.data = data_r;
  assign byte_o.valid = valid_r;
endmodule : cfgc_host_port
`default_nettype wire

/* testbench/cfgc_top_checker.sv */
/*
  Checker for cfgc_top: timed relations between its pins.
  Assumes it is bound to cfgc_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module cfgc_top_checker
  import cfgc_pkg::*;
#(
  parameter int CLEAR_CYCLES_P = 4
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  // straps and init pin
  input wire logic OSC_SPEED_SELECT,
  input wire logic [2:0] CFG_MODE_SELECT,
  input wire logic INIT_IN,
  input wire logic INIT_OUT,
  input wire logic INIT_OE_N,
  input wire logic INIT_PULLUP_EN,
  input wire logic TEST_PULLUP_EN,
  // done and activity
  input wire logic DONE_OUT,
  input wire logic DONE_OE_N,
  input wire logic CFG_ACTIVE_HIGH,
  input wire logic CFG_ACTIVE_LOW,
  // host pins
  input wire logic SELECT_LOW_ACTIVE_N,
  input wire logic SELECT_HIGH_ACTIVE,
  input wire logic HOST_WR_N,
  input wire logic HOST_RD_N,
  input wire logic STATUS_DATA_BIT_OUT,
  input wire logic STATUS_DATA_BIT_OE_N,
  input wire logic READY_PIN_OUT,
  input wire logic READY_PIN_OE_N,
  // oscillator and release
  input wire logic CFG_OSC_TICK,
  input wire logic BSCAN_ENABLE,
  input wire logic USER_IO_RELEASE,
  input wire logic TEST_IO_RELEASE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // ==========================================================
  // expected strap capture
  logic init_r, spd_r, cfg_r;
  logic [2:0] mode_r;
  int lo_cnt_r;
  wire logic cap = INIT_OE_N && INIT_IN && !init_r;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      init_r <= 1'b0;
      spd_r <= 1'b0;
      mode_r <= 3'h0;
      cfg_r <= 1'b0;
    end else begin
      init_r <= INIT_IN;
      if (cap) begin
        spd_r <= OSC_SPEED_SELECT;
        mode_r <= CFG_MODE_SELECT;
      end
      cfg_r <= cap || (cfg_r && CFG_ACTIVE_HIGH && INIT_OE_N);
    end
  end
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) lo_cnt_r <= 0;
    else if (INIT_OE_N) lo_cnt_r <= 0;
    else lo_cnt_r <= lo_cnt_r + 1;
  end
  // ==========================================================
  // assertions
  sequence wr_edge_s;
    !SELECT_LOW_ACTIVE_N && SELECT_HIGH_ACTIVE && $fell(HOST_WR_N);
  endsequence
  sequence rd_sel_s;
    !SELECT_LOW_ACTIVE_N && SELECT_HIGH_ACTIVE && !HOST_RD_N && HOST_WR_N;
  endsequence
  act_pair_a: assert property (CFG_ACTIVE_HIGH == !CFG_ACTIVE_LOW)
    else $error("act pair");
  done_pin_a: assert property (!DONE_OUT && DONE_OE_N == !CFG_ACTIVE_HIGH
    && USER_IO_RELEASE == !CFG_ACTIVE_HIGH) else $error("done pin");
  pull_up_a: assert property (INIT_PULLUP_EN == CFG_ACTIVE_HIGH
    && TEST_PULLUP_EN == CFG_ACTIVE_HIGH) else $error("pull-up");
  bscan_gate_a: assert property ((TEST_IO_RELEASE == !BSCAN_ENABLE)
    && (BSCAN_ENABLE || !CFG_ACTIVE_HIGH)) else $error("scan gate");
  clear_time_a: assert property ($rose(INIT_OE_N) |-> lo_cnt_r >= CLEAR_CYCLES_P)
    else $error("clear time");
  init_low_a: assert property (!INIT_OE_N |-> !INIT_OUT && !CFG_OSC_TICK)
    else $error("init low");
  wait_hold_a: assert property ((INIT_OE_N && !INIT_IN)[*2] |-> !CFG_OSC_TICK)
    else $error("wait hold");
  slow_osc_a: assert property (CFG_OSC_TICK && spd_r |=> !CFG_OSC_TICK[*7])
    else $error("slow tick");
  fast_osc_a: assert property (CFG_OSC_TICK && !spd_r |=>
    CFG_OSC_TICK || !CFG_ACTIVE_HIGH || !INIT_OE_N) else $error("fast tick");
  rd_strobe_a: assert property (cfg_r && mode_r == MODE_MASTER_PAR && CFG_OSC_TICK |=>
    !CFG_ACTIVE_HIGH || (!READY_PIN_OE_N && !READY_PIN_OUT)) else $error("no strobe");
  ale_in_a: assert property (cfg_r && mode_r == MODE_MPI_MUX |-> READY_PIN_OE_N)
    else $error("ale pin driven");
  byte_busy_a: assert property (wr_edge_s ##0 (cfg_r && CFG_ACTIVE_HIGH && READY_PIN_OUT
    && mode_r[2:1] == 2'b10 + mode_r[1]) |-> ##[1:3] !READY_PIN_OUT) else $error("no busy");
  d7_status_a: assert property (rd_sel_s[*3] ##0 (cfg_r && mode_r == MODE_ASYNC_PERIPH)
    |-> !STATUS_DATA_BIT_OE_N && STATUS_DATA_BIT_OUT == READY_PIN_OUT) else $error("bad status");
  apb_wait_a: assert property (PSEL && $rose(PENABLE) |=> PREADY ##1 !PREADY)
    else $error("apb wait");
endmodule : cfgc_top_checker
`default_nettype wire

/* testbench/cfgc_host_model.sv */
/*
  Host model: pulled-up init wire, byte writes,
  status reads, address latch enable.
  Assumes one clock shared with the device.
*/
`timescale 1ns/1ps
`default_nettype none
module cfgc_host_model (
  // clock and init wire
  input wire logic clk,
  input wire logic hold_low,
  input wire logic init_oe_n,
  input wire logic init_out,
  output logic init_wire,
  // host pins
  input wire logic d7,
  input wire logic d7_oe_n,
  output logic sel_n,
  output logic sel,
  output logic wr_n,
  output logic rd_n,
  output logic ale_o,
  output logic [7:0] din
);
  // pull-up unless the device or the host holds it low
  assign init_wire = (hold_low || (!init_oe_n && !init_out)) ? 1'b0 : 1'b1;
  initial begin
    sel_n = 1'b1;
    sel = 1'b0;
    wr_n = 1'b1;
    rd_n = 1'b1;
    ale_o = 1'b0;
    din = 8'h00;
  end
  task automatic write_byte(input logic [7:0] b);
    @(posedge clk);
    sel_n <= 1'b0;
    sel <= 1'b1;
    din <= b;
    @(posedge clk);
    wr_n <= 1'b0;
    @(posedge clk);
    wr_n <= 1'b1;
    @(posedge clk);
    sel_n <= 1'b1;
    sel <= 1'b0;
    din <= ~b;
  endtask : write_byte
  task automatic read_status(output logic v);
    @(posedge clk);
    sel_n <= 1'b0;
    sel <= 1'b1;
    @(posedge clk);
    rd_n <= 1'b0;
    repeat (3) @(posedge clk);
    v = (d7_oe_n === 1'b0) ? d7 : 1'bx;
    rd_n <= 1'b1;
    sel_n <= 1'b1;
    sel <= 1'b0;
  endtask : read_status
  task automatic ale(input logic [7:0] a);
    @(posedge clk);
    sel_n <= 1'b0;
    sel <= 1'b1;
    din <= a;
    ale_o <= 1'b1;
    @(posedge clk);
    sel_n <= 1'b1;
    sel <= 1'b0;
    ale_o <= 1'b0;
    din <= ~a;
  endtask : ale
endmodule : cfgc_host_model
`default_nettype wire

/* testbench/config_control_pins_test.sv */
/*
  Bench for cfgc_top: straps, init, bytes,
  strobes, completion, APB.
  Assumes cfgc_host_model as host and the checker bound below.
*/
`timescale 1ns/1ps
`default_nettype none
module config_control_pins_test;
  import cfgc_pkg::*;
  logic CORE_CLK = 1'b0, RST_N = 1'b0, hold_low = 1'b1;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, OSC_SPEED_SELECT = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic [2:0] CFG_MODE_SELECT = 3'h0;
  logic PREADY, PSLVERR, INIT_IN, INIT_OUT, INIT_OE_N, DONE_OE_N, CFG_ACTIVE_HIGH;
  logic CFG_ACTIVE_LOW, sel_n, sel, wr_n, rd_n, ale, d7, d7_oe_n, READY_PIN_OUT;
  logic READY_PIN_OE_N, CFG_OSC_TICK, BSCAN_ENABLE, TEST_IO_RELEASE, v;
  logic [7:0] din, b;
  logic [32:0] exp_q[$], msk_q[$], mon_m;
  int bad_count = 0, n_checks = 0, n, sp;
  cfgc_top #(.CLEAR_CYCLES_P(4)) dut (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'hf),
    .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .PRGM_N(1'b1), .CFG_RESET_N(1'b1),
    .OSC_SPEED_SELECT(OSC_SPEED_SELECT), .CFG_MODE_SELECT(CFG_MODE_SELECT), .INIT_IN(INIT_IN),
    .INIT_OUT(INIT_OUT), .INIT_OE_N(INIT_OE_N), .INIT_PULLUP_EN(), .DONE_OUT(),
    .DONE_OE_N(DONE_OE_N), .CFG_ACTIVE_HIGH(CFG_ACTIVE_HIGH), .CFG_ACTIVE_LOW(CFG_ACTIVE_LOW),
    .SELECT_LOW_ACTIVE_N(sel_n), .SELECT_HIGH_ACTIVE(sel), .HOST_WR_N(wr_n), .HOST_RD_N(rd_n),
    .HOST_DATA_IN(din), .STATUS_DATA_BIT_OUT(d7), .STATUS_DATA_BIT_OE_N(d7_oe_n),
    .READY_PIN_IN(ale), .READY_PIN_OUT(READY_PIN_OUT), .READY_PIN_OE_N(READY_PIN_OE_N),
    .CFG_OSC_TICK(CFG_OSC_TICK), .TEST_PULLUP_EN(), .BSCAN_ENABLE(BSCAN_ENABLE),
    .USER_IO_RELEASE(), .TEST_IO_RELEASE(TEST_IO_RELEASE));
  cfgc_host_model host (.clk(CORE_CLK), .hold_low(hold_low), .init_oe_n(INIT_OE_N),
    .init_out(INIT_OUT), .init_wire(INIT_IN), .d7(d7), .d7_oe_n(d7_oe_n), .sel_n(sel_n),
    .sel(sel), .wr_n(wr_n), .rd_n(rd_n), .ale_o(ale), .din(din));
  // ==========================================================
  // checking and bus tasks
  task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask : check
  task automatic pin(input logic seen, input logic exp, input string msg);
    check({32'h0, seen}, {32'h0, exp}, msg);
  endtask : pin
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [32:0] m);
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do @(posedge CORE_CLK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
    apb(1'b1, a, d, {err, 32'h0}, 33'h1_0000_0000);
  endtask : wr
  // completed transfers are compared against the oldest note
  always @(posedge CORE_CLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && exp_q.size() > 0) begin
      mon_m = msk_q.pop_front();
      check({PSLVERR, PRDATA} & mon_m, exp_q.pop_front() & mon_m, "apb answer");
    end
  end
  task automatic bring_up(input logic [2:0] md, input logic s);
    CFG_MODE_SELECT <= md;
    OSC_SPEED_SELECT <= s;
    hold_low <= 1'b1;
    wr(OFS_CTRL, 32'h4, 1'b0);
    repeat (3) @(posedge CORE_CLK);
    while (INIT_OE_N !== 1'b1) @(posedge CORE_CLK);
    repeat (4) @(posedge CORE_CLK);
    apb(1'b0, OFS_STATUS, 32'h0, 33'h1, 33'h1_0000_0003);
    hold_low <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    CFG_MODE_SELECT <= ~md;
    OSC_SPEED_SELECT <= ~s;
    apb(1'b0, OFS_STATUS, 32'h0, {26'h0, md, 1'b0, s, 2'h2}, 33'h77);
  endtask : bring_up
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // ==========================================================
  // stimulus
  initial begin
    forever #50 CORE_CLK = ~CORE_CLK;
  end
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    bad_count++;
    $display("FAIL %0t watchdog", $time);
    final_report();
  end
  initial begin
    void'($urandom(64210));
    repeat (5) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    pin(CFG_ACTIVE_HIGH, 1'b1, "active high");
    pin(CFG_ACTIVE_LOW, 1'b0, "active low");
    pin(INIT_OE_N, 1'b0, "init drive");
    $display("test reset done");
    for (int m = 4; m < 8; m++) begin
      sp = $urandom() % 2;
      bring_up(3'(m), sp[0]);
      n = 0;
      repeat (80) @(posedge CORE_CLK) n += (CFG_OSC_TICK === 1'b1);
      check(33'(n), sp[0] ? 33'd10 : 33'd80, "tick count");
      b = 8'($urandom());
      if (m == 4) pin(READY_PIN_OE_N, 1'b0, "strobe");
      if (m == 5 || m == 6) begin
        host.write_byte(b);
        repeat (3) @(posedge CORE_CLK);
        pin(READY_PIN_OUT, 1'b0, "full ready");
        host.write_byte(~b);
        if (m == 5) host.read_status(v);
        if (m == 5) pin(v, 1'b0, "busy bit");
        apb(1'b0, OFS_DATA, 32'h0, {24'h1, b}, 33'h1_0000_01ff);
        apb(1'b0, OFS_DATA, 32'h0, 33'h0, 33'h1_0000_0100);
        repeat (3) @(posedge CORE_CLK);
        pin(READY_PIN_OUT, 1'b1, "take ready");
      end
      if (m == 7) host.ale(b);
      if (m == 7) apb(1'b0, OFS_ALE_ADDR, 32'h0, {25'h0, b}, 33'h1_0000_00ff);
      wr(OFS_CTRL, {30'h0, 1'b1, m[0]}, 1'b0);
      repeat (3) @(posedge CORE_CLK);
      pin(CFG_ACTIVE_HIGH, 1'b0, "done high");
      pin(CFG_ACTIVE_LOW, 1'b1, "done low");
      pin(DONE_OE_N, 1'b1, "done pin");
      pin(BSCAN_ENABLE, m[0], "scan enable");
      pin(TEST_IO_RELEASE, !m[0], "test release");
      apb(1'b0, OFS_CTRL, 32'h0, {32'h0, m[0]}, 33'h1_0000_0007);
      $display("test mode %0d done", m);
    end
    wr(OFS_STATUS, 32'hffff_ffff, 1'b1);
    apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0}, {33{1'b1}});
    $display("test refusals done");
    final_report();
  end
endmodule : config_control_pins_test
bind cfgc_top cfgc_top_checker #(.CLEAR_CYCLES_P(CLEAR_CYCLES_P)) chk (.*);
`default_nettype wire
